// *** bench/sadc_afe_model.sv ***
// behavioural analog front end: input multiplexer, sample-and-hold and comparator
`default_nettype none
module sadc_afe_model (
    input  wire logic [1:0]  mux_sel,
    input  wire logic        sample_hold,
    input  wire logic [7:0]  dac_code,
    input  wire logic [31:0] levels,
    output logic             cmp_out
);
    logic [7:0] held_q;
    // track the selected input while sampling, freeze it while bits resolve
    always_latch begin
        if (sample_hold) begin
            held_q <= levels[8 * mux_sel +: 8];
        end
    end
    // input sits half an lsb above its code, so a trial equal to it keeps the bit
    assign cmp_out = (held_q >= dac_code);
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// testbench: register level tests of the converter sequencer with a front end model
`include "sadc_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] lv = 32'h33A75C21;
    logic        timer0_ovf = 1'b0;
    logic        external_trigger_pin = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, cmp_out, sample_hold, dac_pin_en, irq, wake;
    logic [1:0]  mux_sel;
    logic [7:0]  dac_code;
    logic [31:0] bt [3] = '{32'h3F109003, 32'h84808603, 32'h84808201};
    int          fail_count = 0;
    int          samples_checked = 0;
    int          sh_n = 0;
    sadc_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer0_ovf(timer0_ovf),
        .external_trigger_pin(external_trigger_pin), .cmp_out(cmp_out),
        .mux_sel(mux_sel), .sample_hold(sample_hold), .dac_code(dac_code),
        .dac_pin_en(dac_pin_en), .irq(irq), .wake(wake));
    sadc_afe_model afe (.mux_sel(mux_sel), .sample_hold(sample_hold),
        .dac_code(dac_code), .levels(lv), .cmp_out(cmp_out));
    // 200 mhz clock
    always #2.5 pclk = ~pclk;
    // sampling span, used to see the clock divider at work
    always @(posedge pclk) begin
        if (sample_hold === 1'b1) sh_n++;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask
    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) fail_count++;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    // bounded poll of the done flag
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, `SADC_OFF_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 300);
        chk("done", {31'h0, rd[0]}, 32'h1);
    endtask
    // abort, clear both flags and report the test
    task automatic stop(input string nm);
        apb(1'b1, `SADC_OFF_CTRL, 32'h0);
        apb(1'b1, `SADC_OFF_STAT, 32'h3);
        $display("test %s done", nm);
    endtask
    // ctrl word with the converter enabled
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] s,
        input logic st, input logic [2:0] dv, input logic bnd, input logic ie,
        input logic dac);
        return {19'h0, bnd, ie, dv, dac, 1'b1, s, st, m};
    endfunction
    task automatic go(input logic [31:0] chs, input logic [31:0] c);
        apb(1'b1, `SADC_OFF_CHSEL, chs);
        apb(1'b1, `SADC_OFF_CTRL, c);
    endtask
    // hang guard, well beyond the expected run
    initial begin
        #100us;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl", `SADC_OFF_CTRL, 32'h0);
        rchk("bhi", `SADC_OFF_BHI, 32'hFF);
        rchk("blo", `SADC_OFF_BLO, 32'h0);
        rchk("res0", `SADC_OFF_RES0, 32'h0);
        apb(1'b1, 8'h28, 32'hFF);
        chk("slverr", {31'h0, err}, 32'h1);
        stop("reset");
        go(32'h2, ctl(3'h0, 2'h2, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0));
        wait_done();
        rchk("res2", `SADC_OFF_RES2, 32'hA7);
        chk("irq", {31'h0, irq}, 32'h1);
        rchk("stat", `SADC_OFF_STAT, 32'h1);
        apb(1'b1, `SADC_OFF_STAT, 32'h1);
        rchk("stat", `SADC_OFF_STAT, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        stop("fixed single");
        go(32'h1, ctl(3'h1, 2'h2, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0));
        wait_done();
        chk("active", {31'h0, rd[3]}, 32'h1);
        for (int i = 0; i < 4; i++) rchk("res", 8'(20 + 4 * i), 32'h5C);
        stop("fixed continuous");
        go(32'h300, ctl(3'h4, 2'h2, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0));
        wait_done();
        for (int i = 0; i < 4; i++) begin
            rchk("dual", 8'(20 + 4 * i), (i % 2) ? 32'h33 : 32'h21);
        end
        stop("dual");
        lv = 32'hC4A76E21;
        go(32'h28, ctl(3'h2, 2'h2, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0));
        wait_done();
        rchk("stat", `SADC_OFF_STAT, 32'h1);
        rchk("res1", `SADC_OFF_RES1, 32'h6E);
        rchk("res3", `SADC_OFF_RES3, 32'hC4);
        rchk("res2", `SADC_OFF_RES2, 32'h21);
        stop("scan single");
        lv = 32'hC4A74B90;
        go(32'h0C, ctl(3'h2, 2'h2, 1'b1, 3'h0, 1'b0, 1'b1, 1'b0));
        wait_done();
        rchk("res0", `SADC_OFF_RES0, 32'h90);
        rchk("res1", `SADC_OFF_RES1, 32'h6E);
        apb(1'b1, `SADC_OFF_STAT, 32'h1);
        apb(1'b1, `SADC_OFF_CTRL, ctl(3'h2, 2'h2, 1'b1, 3'h0, 1'b0, 1'b1, 1'b0));
        wait_done();
        rchk("res1", `SADC_OFF_RES1, 32'h4B);
        stop("single step");
        go(32'h0C, ctl(3'h3, 2'h2, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0));
        wait_done();
        apb(1'b1, `SADC_OFF_STAT, 32'h1);
        wait_done();
        stop("scan continuous");
        // timer source, then pin edge; the second trigger lands mid conversion
        for (int k = 0; k < 2; k++) begin
            lv[7:0] = k ? 8'h4D : 8'h90;
            go(32'h0, ctl(3'h0, k ? 2'h3 : 2'h1, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0));
            repeat (60) @(posedge pclk);
            rchk("no start", `SADC_OFF_STAT, 32'h0);
            repeat (2) begin
                @(posedge pclk);
                if (k == 0) timer0_ovf <= 1'b1;
                else external_trigger_pin <= ~external_trigger_pin;
                @(posedge pclk);
                timer0_ovf <= 1'b0;
                repeat (10) @(posedge pclk);
            end
            wait_done();
            rchk("stat", `SADC_OFF_STAT, 32'h1);
            rchk("res0", `SADC_OFF_RES0, {24'h0, lv[7:0]});
            stop("trigger");
        end
        // limits: outside on the upper nibble, outside on eight bits, inside
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `SADC_OFF_BHI, {24'h0, bt[k][31:24]});
            apb(1'b1, `SADC_OFF_BLO, {24'h0, bt[k][23:16]});
            lv[7:0] = bt[k][15:8];
            go(32'h0, ctl(3'h0, 2'h2, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0));
            wait_done();
            rchk("stat", `SADC_OFF_STAT, {24'h0, bt[k][7:0]});
            chk("irq", {31'h0, irq}, {31'h0, bt[k][1]});
            stop("limits");
        end
        lv[7:0] = 8'h86;
        go(32'h0, ctl(3'h0, 2'h2, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0));
        wait_done();
        chk("irq", {31'h0, irq}, 32'h0);
        stop("limit disable");
        for (int k = 0; k < 8; k += 7) begin
            sh_n = 0;
            go(32'h0, ctl(3'h0, 2'h2, 1'b0, 3'(k), 1'b0, 1'b1, 1'b0));
            wait_done();
            chk("span", {31'h0, sh_n >= 3 * k + 4 && sh_n <= 4 * k + 5}, 32'h1);
            stop("divider");
        end
        apb(1'b1, `SADC_OFF_PWR, 32'h2);
        go(32'h0, ctl(3'h0, 2'h2, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0));
        repeat (60) @(posedge pclk);
        rchk("stat", `SADC_OFF_STAT, 32'h0);
        apb(1'b1, `SADC_OFF_PWR, 32'h1);
        go(32'h0, ctl(3'h0, 2'h2, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0));
        wait_done();
        chk("wake", {31'h0, wake}, 32'h1);
        apb(1'b1, `SADC_OFF_PWR, 32'h0);
        stop("power");
        apb(1'b1, `SADC_OFF_CTRL, ctl(3'h0, 2'h0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1));
        apb(1'b1, `SADC_OFF_RES3, 32'h5A);
        rchk("res3", `SADC_OFF_RES3, 32'h5A);
        chk("dac", {24'h0, dac_code}, 32'h5A);
        chk("pin", {29'h0, dac_pin_en, mux_sel}, 32'h7);
        stop("dac");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** rtl/sadc_defs.svh ***
// register offsets, reset values and timing counts of the converter sequencer
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH
`define SADC_OFF_CTRL    8'h00
`define SADC_OFF_CHSEL   8'h04
`define SADC_OFF_STAT    8'h08
`define SADC_OFF_BHI     8'h0C
`define SADC_OFF_BLO     8'h10
`define SADC_OFF_RES0    8'h14
`define SADC_OFF_RES1    8'h18
`define SADC_OFF_RES2    8'h1C
`define SADC_OFF_RES3    8'h20
`define SADC_OFF_PWR     8'h24
`define SADC_RST_CTRL    13'h0000
`define SADC_RST_CHSEL   10'h000
`define SADC_RST_BHI     8'hFF
`define SADC_RST_BLO     8'h00
`define SADC_RST_RES     8'h00
`define SADC_SAR_MSB     8'h80
`define SADC_MSB_IDX     3'h7
`define SADC_NIB_IDX     3'h4
`define SADC_LAST_SLOT   2'h3
`define SADC_DAC_CH      2'h3
`define SADC_SAMPLE_TICKS 3'h3
`define SADC_BIT_TICKS   3'h3
`define SADC_STAT_DONE   0
`define SADC_STAT_BND    1
`endif

// *** rtl/sadc_pkg.sv ***
// types shared by the converter sequencer
`default_nettype none
package sadc_pkg;
    typedef enum logic [2:0] {
        SADC_FIXED_SINGLE = 3'h0,
        SADC_FIXED_CONT   = 3'h1,
        SADC_SCAN_SINGLE  = 3'h2,
        SADC_SCAN_CONT    = 3'h3,
        SADC_DUAL_CONT    = 3'h4
    } sadc_mode_type;
    typedef enum logic [1:0] {
        SADC_SRC_NONE  = 2'h0,
        SADC_SRC_TIMER = 2'h1,
        SADC_SRC_IMM   = 2'h2,
        SADC_SRC_EDGE  = 2'h3
    } sadc_src_type;
    typedef enum logic [3:0] {
        SADC_ST_IDLE   = 4'h1,
        SADC_ST_SAMPLE = 4'h2,
        SADC_ST_CONV   = 4'h4,
        SADC_ST_STORE  = 4'h8
    } sadc_state_type;
    typedef struct packed {
        logic       ie_bnd;
        logic       ie_done;
        logic [2:0] clkdiv;
        logic       dac_en;
        logic       enable;
        logic [1:0] src;
        logic       step;
        logic [2:0] mode;
    } sadc_ctrl_type;
    typedef struct packed {
        logic [1:0] dual_b;
        logic [1:0] dual_a;
        logic [3:0] scan_mask;
        logic [1:0] fixed_ch;
    } sadc_chsel_type;
endpackage
`default_nettype wire

// *** rtl/sadc_seq.sv ***
// converter sequencer: apb registers, start sources, sar control, limits and dac mode
// Behaviour
// - fixed single converts once into channel register
// - fixed continuous rotates results over four registers
// - fixed continuous flags done every four
// - continuous modes run until software stops
// - scan single converts each selected channel once
// - scan continuous flags per pass, restarts scan
// - dual mode stores a,b,a,b into slots
// - dual mode flags done every four conversions
// - single step converts one channel, then waits
// - timer overflow starts conversion when selected
// - timer overflows ignored during a conversion
// - immediate source starts conversion at once
// - pin edges start conversion, ignored while busy
// - compare upper nibble against limits early
// - inside early, compare full result later
// - limit enable clear suppresses limit interrupts
// - dac mode drives result three to pin
// - internal clock divided by one to eight
// - converter runs in idle, completion wakes when done interrupt is enabled
// - power down stops the converter
// - eight bit successive approximation with comparator
`include "sadc_defs.svh"
`default_nettype none
module sadc_seq (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer0_ovf,
    input  wire logic        external_trigger_pin,
    input  wire logic        cmp_out,
    output logic      [1:0]  mux_sel,
    output logic             sample_hold,
    output logic      [7:0]  dac_code,
    output logic             dac_pin_en,
    output logic             irq,
    output logic             wake
);
    sadc_pkg::sadc_ctrl_type  ctrl_q;
    sadc_pkg::sadc_chsel_type chsel_q;
    sadc_pkg::sadc_state_type st_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    logic [7:0]  bhi_q, blo_q;
    logic [7:0]  res_q [4];
    logic        done_q, bnd_q, idle_q, pd_q;
    logic        trig_s1_q, trig_s2_q, trig_s3_q, cmp_s1_q, cmp_s2_q;
    logic [2:0]  div_q, lim_q, ph_q, bit_q;
    logic        tick;
    logic [7:0]  sar_q;
    logic [1:0]  chan_q, slot_q, mux_q;
    logic        run_q, early_q, sample_q, dacen_q, irq_q, wake_q, imm_q;
    logic        acc, wr, imm_pulse, start_evt, go, abort, resolve, nib_out, full_out;
    logic        done_set, bnd_set, done_clr, bnd_clr, wr_res3;
    logic [7:0]  sar_res;
    logic [2:0]  nx_scan, first_scan;
    logic [1:0]  dest, nxt_ch, nxt_slot, init_ch;
    logic        fin, keep, chain;
    sadc_pkg::sadc_ctrl_type  wctrl;

    // lowest selected channel at or above lo; bit 2 flags that one exists
    function automatic logic [2:0] sel_from(input logic [3:0] m, input logic [2:0] lo);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i] && (3'(i) >= lo)) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign mux_sel     = mux_q;
    assign sample_hold = sample_q;
    assign dac_code    = sar_q;
    assign dac_pin_en  = dacen_q;
    assign irq         = irq_q;
    assign wake        = wake_q;

    // bus strobes; a write lands on the edge that sees pready high
    assign acc       = psel && penable && pready_q;
    assign wr        = acc && pwrite;
    assign wctrl     = pwdata[$bits(sadc_pkg::sadc_ctrl_type)-1:0];
    assign imm_pulse = wr && (paddr == `SADC_OFF_CTRL) && wctrl.enable
                       && (wctrl.src == sadc_pkg::SADC_SRC_IMM);
    assign wr_res3   = wr && (paddr == `SADC_OFF_RES3);
    assign done_clr  = wr && (paddr == `SADC_OFF_STAT) && pwdata[`SADC_STAT_DONE];
    assign bnd_clr   = wr && (paddr == `SADC_OFF_STAT) && pwdata[`SADC_STAT_BND];

    // one wait state per access; read data captured with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= 1'b0;
            if (psel && penable && !pready_q) begin
                prdata_q <= 32'h0000_0000;
                unique case (paddr)
                    `SADC_OFF_CTRL:  prdata_q <= 32'(ctrl_q);
                    `SADC_OFF_CHSEL: prdata_q <= 32'(chsel_q);
                    `SADC_OFF_STAT:  prdata_q <= 32'({run_q, !st_q[0], bnd_q, done_q});
                    `SADC_OFF_BHI:   prdata_q <= 32'(bhi_q);
                    `SADC_OFF_BLO:   prdata_q <= 32'(blo_q);
                    `SADC_OFF_RES0:  prdata_q <= 32'(res_q[0]);
                    `SADC_OFF_RES1:  prdata_q <= 32'(res_q[1]);
                    `SADC_OFF_RES2:  prdata_q <= 32'(res_q[2]);
                    `SADC_OFF_RES3:  prdata_q <= 32'(res_q[3]);
                    `SADC_OFF_PWR:   prdata_q <= 32'({pd_q, idle_q});
                    default:         pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // software control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `SADC_RST_CTRL;
            chsel_q <= `SADC_RST_CHSEL;
            bhi_q   <= `SADC_RST_BHI;
            blo_q   <= `SADC_RST_BLO;
            idle_q  <= 1'b0;
            pd_q    <= 1'b0;
        end else if (wr) begin
            if (paddr == `SADC_OFF_CTRL)  ctrl_q  <= wctrl;
            if (paddr == `SADC_OFF_CHSEL) chsel_q <= pwdata[$bits(sadc_pkg::sadc_chsel_type)-1:0];
            if (paddr == `SADC_OFF_BHI)   bhi_q   <= pwdata[7:0];
            if (paddr == `SADC_OFF_BLO)   blo_q   <= pwdata[7:0];
            if (paddr == `SADC_OFF_PWR)   {pd_q, idle_q} <= pwdata[1:0];
        end
    end

    // pin and comparator cross domains; immediate start waits a cycle for the enable to land
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {trig_s1_q, trig_s2_q, trig_s3_q} <= 3'h0;
            {cmp_s1_q, cmp_s2_q, imm_q}       <= 3'h0;
        end else begin
            trig_s1_q <= external_trigger_pin;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            cmp_s1_q  <= cmp_out;
            cmp_s2_q  <= cmp_s1_q;
            imm_q     <= imm_pulse;
        end
    end

    // start only accepted while idle, so busy-time triggers fall away
    always_comb begin
        unique case (sadc_pkg::sadc_src_type'(ctrl_q.src))
            sadc_pkg::SADC_SRC_TIMER: start_evt = timer0_ovf;
            sadc_pkg::SADC_SRC_EDGE:  start_evt = trig_s2_q ^ trig_s3_q;
            default:                  start_evt = 1'b0;
        endcase
        start_evt = start_evt || imm_q;
    end
    assign abort = !ctrl_q.enable || pd_q || ctrl_q.dac_en;
    assign go    = st_q[0] && start_evt && !abort;

    // divider: ratio reloads only at a tick, so a rewrite never cuts a running period short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {div_q, lim_q} <= 6'h00;
        end else begin
            div_q <= tick ? 3'h0 : div_q + 3'h1;
            if (tick) lim_q <= ctrl_q.clkdiv;
        end
    end
    assign tick = (div_q >= lim_q);

    // limit checks on the upper nibble, then on the whole byte
    assign sar_res  = cmp_s2_q ? sar_q : (sar_q & ~(8'h01 << bit_q));
    assign resolve  = st_q[2] && tick && (ph_q == `SADC_BIT_TICKS);
    assign nib_out  = (sar_res[7:4] > bhi_q[7:4]) || (sar_res[7:4] < blo_q[7:4]);
    assign full_out = (sar_res > bhi_q) || (sar_res < blo_q);

    // where the finished result goes and what follows it
    always_comb begin
        nx_scan    = sel_from(chsel_q.scan_mask, {1'b0, chan_q} + 3'h1);
        first_scan = sel_from(chsel_q.scan_mask, 3'h0);
        dest       = chan_q;
        nxt_ch     = chan_q;
        nxt_slot   = slot_q + 2'h1;
        fin        = 1'b1;
        keep       = 1'b0;
        unique case (sadc_pkg::sadc_mode_type'(ctrl_q.mode))
            sadc_pkg::SADC_FIXED_CONT: begin
                dest = slot_q;
                fin  = (slot_q == `SADC_LAST_SLOT);
                keep = 1'b1;
            end
            sadc_pkg::SADC_SCAN_SINGLE: begin
                fin    = !nx_scan[2] || ctrl_q.step;
                keep   = nx_scan[2];
                nxt_ch = nx_scan[1:0];
            end
            sadc_pkg::SADC_SCAN_CONT: begin
                fin    = !nx_scan[2] || ctrl_q.step;
                keep   = 1'b1;
                nxt_ch = nx_scan[2] ? nx_scan[1:0] : first_scan[1:0];
            end
            sadc_pkg::SADC_DUAL_CONT: begin
                dest   = slot_q;
                fin    = (slot_q == `SADC_LAST_SLOT);
                keep   = 1'b1;
                nxt_ch = slot_q[0] ? chsel_q.dual_a : chsel_q.dual_b;
            end
            default: fin = 1'b1;
        endcase
        chain = keep && !ctrl_q.step && (ctrl_q.src == sadc_pkg::SADC_SRC_IMM);
        unique case (sadc_pkg::sadc_mode_type'(ctrl_q.mode))
            sadc_pkg::SADC_SCAN_SINGLE, sadc_pkg::SADC_SCAN_CONT: init_ch = first_scan[1:0];
            sadc_pkg::SADC_DUAL_CONT: init_ch = chsel_q.dual_a;
            default:                  init_ch = chsel_q.fixed_ch;
        endcase
    end

    // conversion state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= sadc_pkg::SADC_ST_IDLE;
            run_q    <= 1'b0;
            chan_q   <= 2'h0;
            slot_q   <= 2'h0;
            ph_q     <= 3'h0;
            bit_q    <= 3'h0;
            sample_q <= 1'b0;
            early_q  <= 1'b0;
        end else if (abort) begin
            st_q     <= sadc_pkg::SADC_ST_IDLE;
            run_q    <= 1'b0;
            sample_q <= 1'b0;
        end else begin
            unique case (st_q)
                sadc_pkg::SADC_ST_IDLE: if (go) begin
                    st_q     <= sadc_pkg::SADC_ST_SAMPLE;
                    run_q    <= 1'b1;
                    sample_q <= 1'b1;
                    ph_q     <= 3'h0;
                    if (!run_q) begin
                        chan_q <= init_ch;
                        slot_q <= 2'h0;
                    end
                end
                sadc_pkg::SADC_ST_SAMPLE: if (tick) begin
                    ph_q <= ph_q + 3'h1;
                    if (ph_q == `SADC_SAMPLE_TICKS) begin
                        st_q     <= sadc_pkg::SADC_ST_CONV;
                        sample_q <= 1'b0;
                        ph_q     <= 3'h0;
                        bit_q    <= `SADC_MSB_IDX;
                        early_q  <= 1'b0;
                    end
                end
                sadc_pkg::SADC_ST_CONV: if (tick) begin
                    ph_q <= ph_q + 3'h1;
                    if (resolve) begin
                        ph_q  <= 3'h0;
                        bit_q <= bit_q - 3'h1;
                        if (bit_q == `SADC_NIB_IDX) early_q <= nib_out;
                        if (bit_q == 3'h0) st_q <= sadc_pkg::SADC_ST_STORE;
                    end
                end
                sadc_pkg::SADC_ST_STORE: begin
                    chan_q   <= nxt_ch;
                    slot_q   <= nxt_slot;
                    run_q    <= keep;
                    st_q     <= chain ? sadc_pkg::SADC_ST_SAMPLE : sadc_pkg::SADC_ST_IDLE;
                    sample_q <= chain;
                    ph_q     <= 3'h0;
                end
                default: st_q <= sadc_pkg::SADC_ST_IDLE;
            endcase
        end
    end

    // sar word doubles as the dac code; in dac mode it follows result three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_q   <= `SADC_RST_RES;
            mux_q   <= 2'h0;
            dacen_q <= 1'b0;
        end else begin
            dacen_q <= ctrl_q.dac_en;
            mux_q   <= ctrl_q.dac_en ? `SADC_DAC_CH : chan_q;
            if (ctrl_q.dac_en) begin
                sar_q <= res_q[3];
            end else if (st_q[1] && tick && ph_q == `SADC_SAMPLE_TICKS) begin
                sar_q <= `SADC_SAR_MSB;
            end else if (resolve) begin
                sar_q <= (bit_q == 3'h0) ? sar_res : (sar_res | (8'h01 << (bit_q - 3'h1)));
            end
        end
    end

    // result registers; hardware store wins over a software write of slot three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) res_q[i] <= `SADC_RST_RES;
        end else begin
            if (wr_res3) res_q[3] <= pwdata[7:0];
            if (st_q[3] && !abort) res_q[dest] <= sar_q;
        end
    end

    // status flags: set beats a same-cycle clear
    assign done_set = st_q[3] && !abort && fin;
    assign bnd_set  = resolve && !abort && !early_q && ((bit_q == `SADC_NIB_IDX && nib_out)
                      || (bit_q == 3'h0 && full_out));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            bnd_q  <= 1'b0;
        end else begin
            done_q <= done_set || (done_q && !done_clr);
            bnd_q  <= bnd_set || (bnd_q && !bnd_clr);
        end
    end

    // request line and idle wake-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q  <= (done_q && ctrl_q.ie_done) || (bnd_q && ctrl_q.ie_bnd);
            wake_q <= idle_q && done_q && ctrl_q.ie_done;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_quiet7;
        !tick [*7];
    endsequence
    property p_div_eight;
        tick && ctrl_q.clkdiv == 3'h7 && $stable(ctrl_q) |=> s_quiet7 ##1 tick;
    endproperty
    a_div_eight: assert property (p_div_eight) else $error("divider period wrong");

    property p_single_stops;
        st_q[3] && !abort && ctrl_q.mode == sadc_pkg::SADC_FIXED_SINGLE |=> !run_q && done_q;
    endproperty
    a_single_stops: assert property (p_single_stops) else $error("single mode kept running");

    property p_busy_ignore;
        st_q[2] && start_evt && !abort |=> !st_q[0] && !st_q[1];
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("start taken while busy");

    property p_early_bound;
        resolve && !abort && bit_q == `SADC_NIB_IDX && nib_out |=> bnd_q;
    endproperty
    a_early_bound: assert property (p_early_bound) else $error("nibble limit missed");

    property p_dac_follow;
        ctrl_q.dac_en && $past(ctrl_q.dac_en) |-> dac_code == $past(res_q[3]);
    endproperty
    a_dac_follow: assert property (p_dac_follow) else $error("dac code stale");

    property p_pd_halt;
        pd_q |=> st_q == sadc_pkg::SADC_ST_IDLE && !sample_hold;
    endproperty
    a_pd_halt: assert property (p_pd_halt) else $error("converter ran in power down");

    property p_wake;
        idle_q && done_q && ctrl_q.ie_done |=> wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no idle wake");

    property p_group_four;
        st_q[3] && !abort && ctrl_q.mode == sadc_pkg::SADC_FIXED_CONT
        && slot_q == `SADC_LAST_SLOT |=> done_q && slot_q == 2'h0;
    endproperty
    a_group_four: assert property (p_group_four) else $error("group of four not flagged");

    property p_set_wins;
        done_set && done_clr |=> done_q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("done lost to clear");
endmodule
`default_nettype wire
